// [rtl/meter_config_register_bank.sv]
// Register bank for meter thresholds and the primary configuration word
// What this block does
// RULE1: Every register loads its default on reset.
// RULE2: Checksum sums flagged critical registers only.
// RULE3: Protectable registers lock separately per writer.
// RULE4: Host never writes reserved register addresses.
// RULE5: Host writes zero to fixed-zero bits.
// RULE6: Host writes one to fixed-one bits.
// RULE7: Current zero-cross threshold resets, checksum covered.
// RULE8: Voltage zero-cross threshold resets, checksum covered.
// RULE9: Coil integrator gain resets, checksum covered.
// RULE10: Gain calibration scale resets, checksum covered.
// RULE11: Interrupt polarity bit: clear low, set high.
// RULE12: Second current gain: 00 ten, 10 fifty.
// RULE13: First current gain: 00 ten, 10 fifty.
// RULE14: Oscillator disable stops crystal, pin is clock.
// RULE15: Zero-cross select: clear channel one, set two.
// RULE16: Page plus six-bit address; fixed bits read fixed.
`timescale 1ns/1ps
module meter_config_register_bank (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Host register port
  input  wire meter_cfg_pkg::bus_req_type  host_req_i,
  output logic                      [23:0] rdata_o,
  output logic                             rvalid_o,
  // Signal processor write port
  input  wire meter_cfg_pkg::bus_req_type  dsp_req_i,
  // Write protect per register slot
  input  wire logic                 [10:0] host_lock_i,
  input  wire logic                 [10:0] dsp_lock_i,
  // Register checksum
  output logic                      [23:0] checksum_o,
  // Datapath events
  input  wire logic                        irq_event_i,
  input  wire logic                        i1_zero_cross_i,
  input  wire logic                        i2_zero_cross_i,
  // Configuration outputs
  output meter_cfg_pkg::cfg_type           cfg_o,
  output logic                             irq_o,
  output logic                             zero_cross_o,
  output logic                             osc_enable_o
);

  localparam int N = meter_cfg_pkg::NUM_REGS;

  meter_cfg_pkg::bank_state_type q;
  meter_cfg_pkg::bank_state_type d;

  logic [N-1:0]       host_hit;
  logic [N-1:0]       host_we;
  logic [N-1:0]       dsp_we;
  logic [N-1:0][23:0] vals;
  logic [23:0]        cfg_word;

  // Address decode: page together with six-bit address
  always_comb begin
    for (int i = 0; i < N; i++) begin
      host_hit[i] = (host_req_i.page == meter_cfg_pkg::REG_PAGE[i]) // RULE16
                 && (host_req_i.addr == meter_cfg_pkg::REG_ADDR[i]);
      host_we[i]  = host_req_i.wr && host_hit[i];
      dsp_we[i]   = dsp_req_i.wr
                 && (dsp_req_i.page == meter_cfg_pkg::REG_PAGE[i])
                 && (dsp_req_i.addr == meter_cfg_pkg::REG_ADDR[i]);
    end
  end

  // One register cell per mapped slot
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_cell
      reg_cell #(
        .RESET_VAL  (meter_cfg_pkg::REG_RESET[g]), // RULE7 RULE8 RULE9 RULE10
        .WMASK      (meter_cfg_pkg::REG_WMASK[g]),
        .HOST_LOCKS (meter_cfg_pkg::HOST_LOCKABLE[g]),
        .DSP_LOCKS  (meter_cfg_pkg::DSP_LOCKABLE[g])
      ) u_cell (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .host_we_i   (host_we[g]),
        .host_lock_i (host_lock_i[g]),
        .host_data_i (host_req_i.data),
        .dsp_we_i    (dsp_we[g]),
        .dsp_lock_i  (dsp_lock_i[g]),
        .dsp_data_i  (dsp_req_i.data),
        .value_o     (vals[g])
      );
    end
  endgenerate

  assign cfg_word = vals[meter_cfg_pkg::IDX_CONFIG];

  // Next state: read mux, checksum, configuration fan-out
  always_comb begin
    d = q;
    d.after_reset = 1'b0;
    // Unmapped reads answer zero
    d.rvalid = host_req_i.rd;
    if (host_req_i.rd) begin
      d.rdata = 24'h000000;
      for (int i = 0; i < N; i++) begin
        if (host_hit[i]) begin
          d.rdata = (vals[i] & meter_cfg_pkg::REG_WMASK[i]) // RULE16
                  | (meter_cfg_pkg::REG_RESET[i]
                     & ~meter_cfg_pkg::REG_WMASK[i]);
        end
      end
    end
    // Sum of critical registers, modulo 2^24
    d.checksum = 24'h000000;
    for (int i = 0; i < N; i++) begin
      if (meter_cfg_pkg::CSUM_MEMBER[i]) begin // RULE2
        d.checksum = d.checksum + vals[i];
      end
    end
    // Primary configuration fields
    d.cfg.irq_pol     = cfg_word[meter_cfg_pkg::INTERRUPT_POLARITY_SELECT_BIT];
    d.cfg.i2_gain     = cfg_word[meter_cfg_pkg::I2_GAIN_LSB +: 2]; // RULE12
    d.cfg.i1_gain     = cfg_word[meter_cfg_pkg::I1_GAIN_LSB +: 2]; // RULE13
    d.cfg.osc_disable = cfg_word[meter_cfg_pkg::OSC_DIS_BIT];
    d.cfg.zx_sel      = cfg_word[meter_cfg_pkg::ZX_SEL_BIT];
    // Stopped oscillator leaves the crystal pin as a clock input
    d.osc_enable = !q.cfg.osc_disable; // RULE14
    // Interrupt level follows the polarity bit
    d.irq = q.cfg.irq_pol ? irq_event_i : !irq_event_i; // RULE11
    // Zero-cross source channel
    d.zero_cross = q.cfg.zx_sel ? i2_zero_cross_i // RULE15
                                : i1_zero_cross_i;
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.rdata       <= 24'h000000;
      q.rvalid      <= 1'b0;
      q.checksum    <= 24'h000000;
      q.cfg         <= '0;
      q.irq         <= 1'b1;
      q.zero_cross  <= 1'b0;
      q.osc_enable  <= 1'b1;
      q.after_reset <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign rdata_o      = q.rdata;
  assign rvalid_o     = q.rvalid;
  assign checksum_o   = q.checksum;
  assign cfg_o        = q.cfg;
  assign irq_o        = q.irq;
  assign zero_cross_o = q.zero_cross;
  assign osc_enable_o = q.osc_enable;

  // Helper terms for the checks below
  logic host_locked_try;
  logic dsp_locked_try;
  logic cfg_read;
  logic miss_read;

  assign host_locked_try = |(host_we & host_lock_i
                             & meter_cfg_pkg::HOST_LOCKABLE);
  assign dsp_locked_try  = |(dsp_we & dsp_lock_i
                             & meter_cfg_pkg::DSP_LOCKABLE);
  assign cfg_read  = host_req_i.rd && host_hit[meter_cfg_pkg::IDX_CONFIG];
  assign miss_read = host_req_i.rd && !(|host_hit);

  // Defaults after reset
  AST_ALL_DEFAULTS: assert property ( // RULE1
    @(posedge clk_i) disable iff (rst_i)
    q.after_reset |-> (vals == meter_cfg_pkg::REG_RESET)
      && (cfg_o == '0) && osc_enable_o && irq_o
  ) else $error("register defaults not loaded after reset");

  AST_IZX_DEFAULT: assert property ( // RULE7
    @(posedge clk_i) disable iff (rst_i)
    q.after_reset |-> vals[meter_cfg_pkg::IDX_IZX] == 24'h100000
  ) else $error("current zero-cross threshold default wrong");

  AST_VZX_DEFAULT: assert property ( // RULE8
    @(posedge clk_i) disable iff (rst_i)
    q.after_reset |-> vals[meter_cfg_pkg::IDX_VZX] == 24'h100000
  ) else $error("voltage zero-cross threshold default wrong");

  AST_INTG_DEFAULT: assert property ( // RULE9
    @(posedge clk_i) disable iff (rst_i)
    q.after_reset |-> vals[meter_cfg_pkg::IDX_INTG] == 24'h143958
  ) else $error("integrator gain default wrong");

  AST_SCALE_DEFAULT: assert property ( // RULE10
    @(posedge clk_i) disable iff (rst_i)
    q.after_reset |-> vals[meter_cfg_pkg::IDX_SCALE] == 24'h4CCCCC
  ) else $error("gain calibration scale default wrong");

  // Checksum follows critical registers only
  AST_CSUM_SKIPS_CONFIG: assert property ( // RULE2
    @(posedge clk_i) disable iff (rst_i)
    host_we[meter_cfg_pkg::IDX_CONFIG] && !(|dsp_we)
      |=> ##1 checksum_o == $past(checksum_o)
  ) else $error("checksum moved on a configuration write");

  AST_CSUM_TRACKS_CRITICAL: assert property ( // RULE2
    @(posedge clk_i) disable iff (rst_i)
    host_we[meter_cfg_pkg::IDX_IZX] && !(|dsp_we)
      && !host_lock_i[meter_cfg_pkg::IDX_IZX]
      && (host_req_i.data != vals[meter_cfg_pkg::IDX_IZX])
      |=> ##1 checksum_o != $past(checksum_o)
  ) else $error("checksum ignored a critical register write");

  // Locks block their own writer
  AST_HOST_LOCK: assert property ( // RULE3
    @(posedge clk_i) disable iff (rst_i)
    host_locked_try && !(|dsp_we) |=> $stable(vals)
  ) else $error("locked register took a host write");

  AST_DSP_LOCK: assert property ( // RULE3
    @(posedge clk_i) disable iff (rst_i)
    dsp_locked_try && !(|host_we) |=> $stable(vals)
  ) else $error("locked register took a processor write");

  AST_TALLY_NOT_DSP_LOCKED: assert property ( // RULE3
    @(posedge clk_i) disable iff (rst_i)
    dsp_we[meter_cfg_pkg::IDX_TALLY] && !(|host_we)
      |=> vals[meter_cfg_pkg::IDX_TALLY] == $past(dsp_req_i.data)
  ) else $error("line period tally refused a processor write");

  // Fixed bits and unmapped reads
  AST_FIXED_BITS_READ: assert property ( // RULE16
    @(posedge clk_i) disable iff (rst_i)
    cfg_read |=> rvalid_o
      && ((rdata_o & ~meter_cfg_pkg::REG_WMASK[0])
          == (meter_cfg_pkg::REG_RESET[0]
              & ~meter_cfg_pkg::REG_WMASK[0]))
  ) else $error("fixed configuration bits read wrong");

  AST_MISS_READ_ZERO: assert property ( // RULE16
    @(posedge clk_i) disable iff (rst_i)
    miss_read |=> rvalid_o && (rdata_o == 24'h000000)
  ) else $error("unmapped read did not answer zero");

  // Configuration fan-out
  AST_IRQ_POLARITY: assert property ( // RULE11
    @(posedge clk_i) disable iff (rst_i)
    !cfg_o.irq_pol |=> irq_o == !$past(irq_event_i)
  ) else $error("interrupt level ignores polarity");

  AST_GAIN_FIELDS: assert property ( // RULE12
    @(posedge clk_i) disable iff (rst_i)
    host_we[meter_cfg_pkg::IDX_CONFIG]
      && !host_lock_i[meter_cfg_pkg::IDX_CONFIG]
      |=> ##1 (cfg_o.i2_gain == $past(host_req_i.data[7:6], 2))
      && (cfg_o.i1_gain == $past(host_req_i.data[5:4], 2)) // RULE13
  ) else $error("gain fields not passed to the amplifiers");

  AST_OSC_DISABLE: assert property ( // RULE14
    @(posedge clk_i) disable iff (rst_i)
    cfg_o.osc_disable |=> !osc_enable_o
  ) else $error("oscillator still enabled while disabled");

  AST_ZX_SELECT: assert property ( // RULE15
    @(posedge clk_i) disable iff (rst_i)
    cfg_o.zx_sel |=> zero_cross_o == $past(i2_zero_cross_i)
  ) else $error("zero-cross source not channel two");

  // Unlocked host write lands and wins a same-cycle clash
  AST_IZX_WRITE: assert property ( // RULE3
    @(posedge clk_i) disable iff (rst_i)
    host_we[meter_cfg_pkg::IDX_IZX] && !host_lock_i[meter_cfg_pkg::IDX_IZX]
      |=> vals[meter_cfg_pkg::IDX_IZX] == $past(host_req_i.data)
  ) else $error("unlocked current threshold write lost");

  AST_HOST_WINS: assert property ( // RULE3
    @(posedge clk_i) disable iff (rst_i)
    host_we[meter_cfg_pkg::IDX_IZX] && dsp_we[meter_cfg_pkg::IDX_IZX]
      && !host_lock_i[meter_cfg_pkg::IDX_IZX]
      && (host_req_i.data != dsp_req_i.data)
      |=> vals[meter_cfg_pkg::IDX_IZX] != $past(dsp_req_i.data)
  ) else $error("processor write beat a same-cycle host write");

  // Reads answer once, with the selected register
  AST_READ_SLOT: assert property ( // RULE16
    @(posedge clk_i) disable iff (rst_i)
    host_req_i.rd && host_hit[meter_cfg_pkg::IDX_SCALE]
      |=> rdata_o == $past(vals[meter_cfg_pkg::IDX_SCALE])
  ) else $error("read did not return the selected register");

  AST_RVALID_AFTER_READ: assert property ( // RULE16
    @(posedge clk_i) disable iff (rst_i)
    host_req_i.rd |=> rvalid_o
  ) else $error("read not answered in the next cycle");

  AST_RVALID_IDLE: assert property ( // RULE16
    @(posedge clk_i) disable iff (rst_i)
    !host_req_i.rd |=> !rvalid_o
  ) else $error("read answer without a read");

  // Fixed configuration bits never move
  AST_CFG_FIXED_HELD: assert property ( // RULE16
    @(posedge clk_i) disable iff (rst_i)
    (vals[meter_cfg_pkg::IDX_CONFIG] & ~meter_cfg_pkg::REG_WMASK[0])
      == (meter_cfg_pkg::REG_RESET[0] & ~meter_cfg_pkg::REG_WMASK[0])
  ) else $error("fixed configuration bits changed");

  // Other polarity, source and oscillator settings
  AST_IRQ_HIGH: assert property ( // RULE11
    @(posedge clk_i) disable iff (rst_i)
    cfg_o.irq_pol |=> irq_o == $past(irq_event_i)
  ) else $error("active-high interrupt level wrong");

  AST_ZX_CHANNEL_ONE: assert property ( // RULE15
    @(posedge clk_i) disable iff (rst_i)
    !cfg_o.zx_sel |=> zero_cross_o == $past(i1_zero_cross_i)
  ) else $error("zero-cross source not channel one");

  AST_OSC_RUNNING: assert property ( // RULE14
    @(posedge clk_i) disable iff (rst_i)
    !cfg_o.osc_disable |=> osc_enable_o
  ) else $error("oscillator stopped while enabled");

  // Main scenarios
  COV_HOST_WRITE: cover property (
    @(posedge clk_i) disable iff (rst_i)
    (|host_we) ##1 host_req_i.rd
  );

  COV_LOCKED_WRITE: cover property (
    @(posedge clk_i) disable iff (rst_i)
    host_locked_try
  );

  COV_HIGH_IRQ: cover property (
    @(posedge clk_i) disable iff (rst_i)
    cfg_o.irq_pol && irq_o
  );

  COV_FIFTY_GAIN: cover property (
    @(posedge clk_i) disable iff (rst_i)
    cfg_o.i1_gain == meter_cfg_pkg::GAIN_50X
  );

  COV_DSP_LOCKED: cover property (
    @(posedge clk_i) disable iff (rst_i)
    dsp_locked_try
  );

endmodule

// [rtl/meter_cfg_pkg.sv]
// Constants and carrier types for the meter configuration register bank
package meter_cfg_pkg;

  localparam int NUM_REGS = 11;
  localparam int DATA_W   = 24;

  // Page numbers
  localparam logic [4:0] CONFIG_PAGE = 5'h00;
  localparam logic [4:0] SOFT_PAGE   = 5'h12;

  // Register slots: 0 config, 1..10 software page
  localparam logic [NUM_REGS-1:0][4:0] REG_PAGE = {
    {10{SOFT_PAGE}}, CONFIG_PAGE
  };
  localparam logic [NUM_REGS-1:0][5:0] REG_ADDR = {
    6'h3F, 6'h3E, 6'h3A, 6'h33, 6'h32, 6'h2F,
    6'h2E, 6'h2B, 6'h1C, 6'h18, 6'h00
  };
  localparam logic [NUM_REGS-1:0][23:0] REG_RESET = {
    24'h4CCCCC, 24'h000064, 24'h100000, 24'h7FFFFF,
    24'h000000, 24'h7FFFFF, 24'h000000, 24'h143958,
    24'h800000, 24'h100000, 24'hC02000
  };
  // Bits that a write may change; others hold their fixed value
  localparam logic [NUM_REGS-1:0][23:0] REG_WMASK = {
    {10{24'hFFFFFF}}, 24'h0001F6
  };

  // Slot indices used by name
  localparam int IDX_CONFIG = 0;
  localparam int IDX_IZX    = 1;
  localparam int IDX_INTG   = 3;
  localparam int IDX_VZX    = 8;
  localparam int IDX_TALLY  = 9;
  localparam int IDX_SCALE  = 10;

  // Checksum membership and lockability per slot
  localparam logic [NUM_REGS-1:0] CSUM_MEMBER   = 11'h7FE;
  localparam logic [NUM_REGS-1:0] HOST_LOCKABLE = 11'h7FE;
  localparam logic [NUM_REGS-1:0] DSP_LOCKABLE  = 11'h5FE;

  // Primary configuration field positions
  localparam int INTERRUPT_POLARITY_SELECT_BIT = 8;
  localparam int I2_GAIN_LSB = 6;
  localparam int I1_GAIN_LSB = 4;
  localparam int OSC_DIS_BIT = 2;
  localparam int ZX_SEL_BIT  = 1;

  // Amplifier gain codes
  localparam logic [1:0] GAIN_10X = 2'h0;
  localparam logic [1:0] GAIN_50X = 2'h2;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  page;
    logic [5:0]  addr;
    logic [23:0] data;
  } bus_req_type;

  typedef struct packed {
    logic       irq_pol;
    logic [1:0] i2_gain;
    logic [1:0] i1_gain;
    logic       osc_disable;
    logic       zx_sel;
  } cfg_type;

  typedef struct packed {
    logic [23:0] value;
  } cell_state_type;

  typedef struct packed {
    logic [23:0] rdata;
    logic        rvalid;
    logic [23:0] checksum;
    cfg_type     cfg;
    logic        irq;
    logic        zero_cross;
    logic        osc_enable;
    logic        after_reset;
  } bank_state_type;

endpackage

// [rtl/reg_cell.sv]
// One 24-bit register with fixed bits and separate write locks
`timescale 1ns/1ps
module reg_cell #(
  parameter logic [23:0] RESET_VAL  = 24'h000000,
  parameter logic [23:0] WMASK      = 24'hFFFFFF,
  parameter bit          HOST_LOCKS = 1'b1,
  parameter bit          DSP_LOCKS  = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Host write
  input  wire logic        host_we_i,
  input  wire logic        host_lock_i,
  input  wire logic [23:0] host_data_i,
  // Signal processor write
  input  wire logic        dsp_we_i,
  input  wire logic        dsp_lock_i,
  input  wire logic [23:0] dsp_data_i,
  // Stored value
  output logic      [23:0] value_o
);

  meter_cfg_pkg::cell_state_type q;
  meter_cfg_pkg::cell_state_type d;

  // An unlocked host write wins a same-cycle clash; fixed bits keep their value
  always_comb begin
    d = q;
    if (host_we_i && !(HOST_LOCKS && host_lock_i)) begin // RULE3
      d.value = (host_data_i & WMASK) | (RESET_VAL & ~WMASK); // RULE16
    end else if (dsp_we_i && !(DSP_LOCKS && dsp_lock_i)) begin // RULE3
      d.value = (dsp_data_i & WMASK) | (RESET_VAL & ~WMASK);
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.value <= RESET_VAL; // RULE1
    end else begin
      q <= d;
    end
  end

  assign value_o = q.value;

endmodule

// [verification/host_model.sv]
// Host side model driving register reads and writes into the bank
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic                       clk_i,
  // Request to the bank
  output meter_cfg_pkg::bus_req_type      req_o,
  // Read answer
  input  wire logic                [23:0] rdata_i,
  input  wire logic                       rvalid_i
);
  initial req_o = '0;

  // True where page and address name a published register
  function automatic bit known(input logic [4:0] p, input logic [5:0] a);
    known = 1'b0;
    for (int i = 0; i < meter_cfg_pkg::NUM_REGS; i++)
      if (meter_cfg_pkg::REG_PAGE[i] == p && meter_cfg_pkg::REG_ADDR[i] == a)
        known = 1'b1;
  endfunction

  // Write one word; fixed config bits are sent at their fixed value
  task automatic wr(input logic [4:0] p, input logic [5:0] a,
                    input logic [23:0] d);
    logic [23:0] v;
    v = d;
    if (p == meter_cfg_pkg::CONFIG_PAGE && a == 6'h00)
      v = (d & meter_cfg_pkg::REG_WMASK[0]) |
          (meter_cfg_pkg::REG_RESET[0] & ~meter_cfg_pkg::REG_WMASK[0]);
    if (known(p, a)) begin
      @(negedge clk_i);
      req_o <= {1'b1, 1'b0, p, a, v};
      @(negedge clk_i);
      req_o <= {1'b0, 1'b0, ~p, ~a, ~v};
    end
  endtask

  // Read one word; released lines carry a changed pattern
  task automatic rd(input logic [4:0] p, input logic [5:0] a,
                    output logic [23:0] d);
    @(negedge clk_i);
    req_o <= {1'b0, 1'b1, p, a, 24'h000000};
    @(negedge clk_i);
    req_o <= {1'b0, 1'b0, ~p, ~a, 24'hA5A5A5};
    for (int n = 0; n < 4 && rvalid_i !== 1'b1; n++)
      @(negedge clk_i);
    d = (rvalid_i === 1'b1) ? rdata_i : 'x;
  endtask
endmodule

// [verification/meter_config_register_bank_bench.sv]
// Self-checking bench for the meter configuration register bank
`timescale 1ns/1ps
module meter_config_register_bank_bench;
  localparam logic [4:0] SP = meter_cfg_pkg::SOFT_PAGE;
  localparam logic [4:0] CP = meter_cfg_pkg::CONFIG_PAGE;
  logic                       clk_i = 1'b0;
  logic                       rst_i = 1'b1;
  meter_cfg_pkg::bus_req_type host_req;
  meter_cfg_pkg::bus_req_type dsp_req = '0;
  meter_cfg_pkg::cfg_type     cfg;
  logic [23:0]                rdata, csum, v, sum;
  logic                       rvalid, irq, zc, osc;
  logic                       irq_ev = 1'b0;
  logic                       z1 = 1'b0;
  logic                       z2 = 1'b0;
  logic [10:0]                hlock = '0;
  logic [10:0]                dlock = '0;
  int                         bad_count = 0;
  int                         total_checks = 0;

  // Clock at 100 MHz
  always #5 clk_i = ~clk_i;

  meter_config_register_bank meter_config_register_bank_i (
    .clk_i(clk_i), .rst_i(rst_i), .host_req_i(host_req),
    .rdata_o(rdata), .rvalid_o(rvalid), .dsp_req_i(dsp_req),
    .host_lock_i(hlock), .dsp_lock_i(dlock), .checksum_o(csum),
    .irq_event_i(irq_ev), .i1_zero_cross_i(z1), .i2_zero_cross_i(z2),
    .cfg_o(cfg), .irq_o(irq), .zero_cross_o(zc), .osc_enable_o(osc)
  );

  host_model host_model_i (
    .clk_i(clk_i), .req_o(host_req), .rdata_i(rdata), .rvalid_i(rvalid)
  );

  // Compare and count
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Processor write on the software page
  task automatic dw(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk_i);
    dsp_req <= {1'b1, 1'b0, SP, a, d};
    @(negedge clk_i);
    dsp_req <= {1'b0, 1'b0, ~SP, ~a, ~d};
  endtask

  // Watchdog against a hang
  initial begin
    #20000;
    bad_count++;
    results();
  end

  // Test sequence
  initial begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    rst_i <= 1'b0;
    // Defaults of every slot, checksum of critical slots
    sum = 24'h000000;
    for (int i = 0; i < meter_cfg_pkg::NUM_REGS; i++) begin
      host_model_i.rd(meter_cfg_pkg::REG_PAGE[i],
                      meter_cfg_pkg::REG_ADDR[i], v);
      chk(v, meter_cfg_pkg::REG_RESET[i]);
      if (i != 0)
        sum = sum + meter_cfg_pkg::REG_RESET[i];
    end
    chk(csum, sum);
    host_model_i.rd(SP, 6'h19, v);
    chk(v, 24'h000000);
    // All configuration fields set
    z2 = 1'b1;
    irq_ev = 1'b1;
    host_model_i.wr(CP, 6'h00, 24'h0001A6);
    repeat (3) @(negedge clk_i);
    chk({17'h0, cfg}, 24'h00006B);
    chk({23'h0, osc}, 24'h000000);
    chk({23'h0, zc}, 24'h000001);
    chk({23'h0, irq}, 24'h000001);
    host_model_i.rd(CP, 6'h00, v);
    chk(v, 24'hC021A6);
    irq_ev = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({23'h0, irq}, 24'h000000);
    // Configuration back to defaults
    host_model_i.wr(CP, 6'h00, 24'h000000);
    repeat (3) @(negedge clk_i);
    chk({17'h0, cfg}, 24'h000000);
    chk({23'h0, osc}, 24'h000001);
    chk({23'h0, zc}, 24'h000000);
    chk({23'h0, irq}, 24'h000001);
    // Host lock refuses, processor lock per slot
    hlock <= 11'h002;
    host_model_i.wr(SP, 6'h18, 24'h123456);
    host_model_i.rd(SP, 6'h18, v);
    chk(v, 24'h100000);
    hlock <= 11'h000;
    host_model_i.wr(SP, 6'h18, 24'h123456);
    // Same-cycle clash: the host write wins
    fork
      host_model_i.wr(SP, 6'h18, 24'h000333);
      dw(6'h18, 24'h000444);
    join
    host_model_i.rd(SP, 6'h18, v);
    chk(v, 24'h000333);
    dlock <= 11'h300;
    dw(6'h3A, 24'h0000AA);
    dw(6'h3E, 24'h000055);
    host_model_i.rd(SP, 6'h3A, v);
    chk(v, 24'h100000);
    host_model_i.rd(SP, 6'h3E, v);
    chk(v, 24'h000055);
    // Checksum follows accepted writes
    host_model_i.wr(SP, 6'h2B, 24'h000001);
    repeat (2) @(negedge clk_i);
    sum = sum - 24'h143958 + 24'h000001 - 24'h000064 + 24'h000055;
    sum = sum - 24'h100000 + 24'h000333;
    chk(csum, sum);
    host_model_i.rd(SP, 6'h2B, v);
    chk(v, 24'h000001);
    results();
  end
endmodule
